//--- bench/clc_top_sva.sv
// Bus handshake and pin idle checks for the logic cell top.
`timescale 1ns/100ps
`include "clc_defines.svh"
module clc_top_sva (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 s_axi_awvalid,
  input  wire logic                 s_axi_awready,
  input  wire logic                 s_axi_wvalid,
  input  wire logic [1:0]           s_axi_bresp,
  input  wire logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic                 s_axi_arvalid,
  input  wire logic                 s_axi_arready,
  input  wire logic [31:0]          s_axi_rdata,
  input  wire logic [1:0]           s_axi_rresp,
  input  wire logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [`CLC_N_IO-1:0] io_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_aw_ready: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write ready does not follow the valids");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
  chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed while waiting");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `CLC_RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carries data");
  chk_pins_idle: assert property ($rose(aresetn) |-> io_oe_n == 4'hF)
    else $error("pins driven after reset");
endmodule : clc_top_sva

bind clc_top clc_top_sva i_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .io_oe_n(io_oe_n)
);

//--- bench/configurable_logic_cell_tb.sv
// Self-checking testbench for the logic cell top.
`timescale 1ns/100ps
`include "clc_defines.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module configurable_logic_cell_tb;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  br, rr;
  logic        aclk, aresetn, awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd;
  logic        gclk, expi, expo, cyi, cyo, csi, cso;
  logic [3:0]  ded, ioi, ioo, oen;
  logic [15:0] tbl;
  logic [2:0]  b;
  int          err_total, check_count, cyc;

  clc_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .gclk_pin(gclk),
    .ded_in(ded), .io_in(ioi), .io_out(ioo), .io_oe_n(oen), .exp_in(expi),
    .exp_out(expo), .carry_in(cyi), .carry_out(cyo), .casc_in(csi), .casc_out(cso));

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'h1;
    wv  <= 1'h1;
    brd <= 1'h1;
    do @(posedge aclk); while (!(awr === 1'h1 && wrd === 1'h1));
    awv <= 1'h0;
    wv  <= 1'h0;
    do @(posedge aclk); while (bv !== 1'h1);
    `CHK(br, e)
    brd <= 1'h0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e,
                        input bit slow);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rrd <= !slow;
    do @(posedge aclk); while (arr !== 1'h1);
    arv <= 1'h0;
    do @(posedge aclk); while (rv !== 1'h1);
    if (slow) begin
      repeat (2) @(posedge aclk);
      rrd <= 1'h1;
      @(posedge aclk);
    end
    `CHK(rd, d)
    `CHK(rr, e)
    rrd <= 1'h0;
  endtask : rd_reg

  // Pins are sampled by aclk, so each change is given time to reach the outputs.
  task automatic pins(input logic [3:0] d, input logic [3:0] i, input logic g,
                      input logic [2:0] x);
    @(posedge aclk);
    ded  <= d;
    ioi  <= i;
    gclk <= g;
    {expi, cyi, csi} <= x;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask : pins

  task automatic test_done(input string s);
    $display("Test %s finished", s);
  endtask : test_done

  task stop_test;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    {awa, ara, wd, awv, wv, brd, arv, rrd} = '0;
    {gclk, ded, ioi, expi, cyi, csi} = '0;
    {err_total, check_count, cyc} = '0;
    tbl = 16'hA5C3;
    aresetn = 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    for (int k = 0; k < 9; k++) begin
      rd_reg(8'(4 * k), (k < 2) ? 32'h0000_0001 : 32'h0000_0000, 2'h0, k == 8);
    end
    rd_reg(8'h30, 32'h0000_0000, 2'h2, 1'h0);
    wr_reg(8'h30, 32'hFFFF_FFFF, 2'h2);
    wr_reg(8'h24, 32'hFFFF_FFFF, 2'h0);
    rd_reg(8'h24, 32'h0000_0000, 2'h0, 1'h0);
    `CHK(oen, 4'hF)
    test_done("registers");
    wr_reg(8'h0C, 32'h0000_3A06, 2'h0);
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    `CHK(oen, 4'hF)
    wr_reg(8'h00, 32'h0001_0001, 2'h0);
    pins(4'h1, 4'h8, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    `CHK(oen, 4'hC)
    wr_reg(8'h10, 32'h0000_0020, 2'h0);
    for (int k = 0; k < 2; k++) begin
      b = 3'(k);
      pins({2'h0, b[0], 1'h0}, 4'h0, 1'h0, 3'h0);
      `CHK(ioo[0], !b[0])
    end
    wr_reg(8'h00, 32'h0002_0001, 2'h0);
    wr_reg(8'h10, 32'h0000_0000, 2'h0);
    wr_reg(8'h14, 32'h0010_0000, 2'h0);
    for (int k = 0; k < 4; k++) begin
      b = 3'(k);
      pins({3'h0, b[1]}, 4'h0, 1'h0, {b[0], 2'h0});
      `CHK(expo, b[1])
      `CHK(ioo[0], b[0] | b[1])
    end
    wr_reg(8'h0C, 32'h0000_3A02, 2'h0);
    wr_reg(8'h20, 32'h0000_0020, 2'h0);
    for (int k = 0; k < 2; k++) begin
      b = 3'(k);
      pins({2'h0, b[0], 1'h0}, 4'h0, 1'h0, 3'h0);
      `CHK(oen[0], !b[0])
    end
    test_done("sum of products");
    wr_reg(8'h0C, 32'h0000_0000, 2'h0);
    wr_reg(8'h08, {16'h0000, tbl}, 2'h0);
    wr_reg(8'h04, 32'h3440_0001, 2'h0);
    for (int k = 0; k < 16; k++) begin
      pins(4'h0, 4'(k), 1'h0, 3'h0);
      `CHK(cso, tbl[k])
      `CHK(cyo, 1'h0)
    end
    wr_reg(8'h04, 32'h3442_0001, 2'h0);
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    `CHK(cso, 1'h0)
    pins(4'h0, 4'h0, 1'h0, 3'h1);
    `CHK(cso, 1'h1)
    wr_reg(8'h04, 32'h3446_0001, 2'h0);
    pins(4'h0, 4'h2, 1'h0, 3'h1);
    `CHK(cso, 1'h1)
    wr_reg(8'h04, 32'h3441_0001, 2'h0);
    for (int k = 0; k < 8; k++) begin
      b = 3'(k);
      pins(4'h0, {2'h0, b[1:0]}, 1'h0, {1'h0, b[2], 1'h0});
      `CHK(cyo, (b[0] & b[1]) | (b[0] & b[2]) | (b[1] & b[2]))
      `CHK(cso, tbl[{1'h0, b}])
    end
    test_done("lookup table");
    wr_reg(8'h14, 32'h0000_0000, 2'h0);
    wr_reg(8'h10, 32'h0000_0020, 2'h0);
    wr_reg(8'h0C, 32'h0000_4101, 2'h0);
    wr_reg(8'h00, 32'h0000_0000, 2'h0);
    pins(4'h2, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    pins(4'h2, 4'h0, 1'h1, 3'h0);
    `CHK(ioo[0], 1'h1)
    pins(4'h0, 4'h0, 1'h1, 3'h0);
    wr_reg(8'h00, 32'h0000_0040, 2'h0);
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    pins(4'h0, 4'h0, 1'h1, 3'h0);
    `CHK(ioo[0], 1'h0)
    wr_reg(8'h18, 32'h0000_0010, 2'h0);
    wr_reg(8'h00, 32'h0000_0048, 2'h0);
    pins(4'h3, 4'h0, 1'h1, 3'h0);
    `CHK(ioo[0], 1'h0)
    pins(4'h2, 4'h0, 1'h1, 3'h0);
    `CHK(ioo[0], 1'h1)
    wr_reg(8'h1C, 32'h0004_0000, 2'h0);
    wr_reg(8'h00, 32'h0000_0088, 2'h0);
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    pins(4'h1, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    pins(4'h0, 4'h4, 1'h0, 3'h0);
    pins(4'h1, 4'h4, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    wr_reg(8'h18, 32'h0002_0010, 2'h0);
    wr_reg(8'h1C, 32'h0004_0008, 2'h0);
    pins(4'h0, 4'h8, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    pins(4'h0, 4'hA, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    pins(4'h0, 4'h8, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    pins(4'h0, 4'h2, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    wr_reg(8'h00, 32'h0000_000A, 2'h0);
    pins(4'h3, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    pins(4'h1, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    pins(4'h2, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    wr_reg(8'h00, 32'h0000_0001, 2'h0);
    pins(4'h2, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    wr_reg(8'h00, 32'h0000_0024, 2'h0);
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    pins(4'h2, 4'h4, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h1)
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    pins(4'h0, 4'h4, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    test_done("sum of products storage");
    wr_reg(8'h08, 32'h0000_0000, 2'h0);
    wr_reg(8'h04, 32'h3440_0040, 2'h0);
    pins(4'h0, 4'h0, 1'h1, 3'h0);
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[1], 1'h0)
    wr_reg(8'h08, 32'h0000_FFFF, 2'h0);
    pins(4'h0, 4'h0, 1'h1, 3'h0);
    `CHK(ioo[1], 1'h0)
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[1], 1'h1)
    wr_reg(8'h04, 32'h3440_0140, 2'h0);
    pins(4'h0, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[1], 1'h0)
    test_done("small cell storage");
    wr_reg(8'h04, 32'h0000_0001, 2'h0);
    wr_reg(8'h00, 32'h0000_0001, 2'h0);
    wr_reg(8'h0C, 32'h0000_0081, 2'h0);
    pins(4'h0, 4'h0, 1'h1, 3'h0);
    pins(4'h2, 4'h0, 1'h0, 3'h0);
    `CHK(ioo[0], 1'h0)
    pins(4'h2, 4'h0, 1'h1, 3'h0);
    `CHK(ioo[0], 1'h1)
    // The held cell output feeds its own term while pin 0 is an input held low.
    wr_reg(8'h0C, 32'h0000_0000, 2'h0);
    wr_reg(8'h10, 32'h0000_0040, 2'h0);
    pins(4'h0, 4'h0, 1'h1, 3'h0);
    `CHK(ioo[0], 1'h1)
    `CHK(oen[0], 1'h1)
    test_done("pin register");
    stop_test();
  end
endmodule : configurable_logic_cell_tb

//--- rtl/clc_defines.svh
// Register offsets, field positions, reset values and term indices of the logic cell.
`ifndef CLC_DEFINES_SVH
`define CLC_DEFINES_SVH
`define CLC_ADDR_W        8
`define CLC_OFS_SOP_CTRL  8'h00
`define CLC_OFS_LUT_CTRL  8'h04
`define CLC_OFS_LUT_TABLE 8'h08
`define CLC_OFS_IO_CTRL   8'h0C
`define CLC_OFS_TERM0     8'h10
`define CLC_TERM_SPAN     8'h14
`define CLC_OFS_STATUS    8'h24
`define CLC_TERM_REGS     5
`define CLC_TERM_W        16
`define CLC_MASK_W        8
`define CLC_N_IO          4
`define CLC_IOCFG_W       8
`define CLC_SCFG_W        11
`define CLC_SOP_INV_BIT   16
`define CLC_SOP_STEAL_BIT 17
`define CLC_LUT_CARRY_BIT 16
`define CLC_LUT_CASC_BIT  17
`define CLC_LUT_COR_BIT   18
`define CLC_LUT_SEL_LSB   19
`define CLC_LUT_SEL_W     3
`define CLC_PT_SUMS       4
`define CLC_PT_CLK        4
`define CLC_PT_CLR        5
`define CLC_PT_PRE        6
`define CLC_PT_ENA        7
`define CLC_PT_OE         8
`define CLC_RST_CTRL      32'h0000_0001
`define CLC_RST_IO        32'h0000_0000
`define CLC_RST_TABLE     16'h0000
`define CLC_RST_TERM      32'h0000_0000
`define CLC_RESP_OKAY     2'h0
`define CLC_RESP_SLVERR   2'h2
`endif

//--- rtl/clc_pkg.sv
// Types shared by the logic cell modules.
package clc_pkg;
  typedef enum logic [1:0] {CLC_CK_GPIN, CLC_CK_PIN, CLC_CK_INT, CLC_CK_RSVD} clc_ck_src_t;
  typedef enum logic [1:0] {CLC_IO_IN, CLC_IO_OUT, CLC_IO_BIDIR, CLC_IO_OFF} clc_io_mode_t;
  typedef enum logic [1:0] {CLC_OE_TERM, CLC_OE_DED, CLC_OE_PIN, CLC_OE_LOGIC} clc_oe_src_t;
  typedef struct packed {
    logic        ena_inv;
    logic        pre_inv;
    logic        clr_inv;
    logic        ena_use;
    logic        falling;
    logic [1:0]  clk_pin;
    clc_ck_src_t clk_src;
    logic        latch;
    logic        bypass;
  } clc_scfg_t;
  typedef struct packed {
    logic         reg_en;
    logic         out_lut;
    logic [1:0]   oe_pin;
    clc_oe_src_t  oe_src;
    clc_io_mode_t mode;
  } clc_iocfg_t;
endpackage : clc_pkg

//--- rtl/clc_sop.sv
// Product-term array, OR sum with borrowed term and output XOR.
`timescale 1ns/100ps
module clc_sop
  import clc_pkg::*;
#(
  parameter int NI = 8,
  parameter int NT = 9,
  parameter int NS = 4
) (
  input  wire logic [NI-1:0]         arr_in,
  input  wire logic [NT-1:0][NI-1:0] tmask,
  input  wire logic [NT-1:0][NI-1:0] cmask,
  input  wire logic                  exp_in,
  input  wire logic                  invert,
  output logic      [NT-1:0]         pterm,
  output logic                       sum_y
);
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      // A term with no connections reads zero so it never pollutes the sum.
      pterm[t] = (|(tmask[t] | cmask[t])) && (&(~tmask[t] | arr_in))
                 && (&(~cmask[t] | ~arr_in));
    end
    sum_y = ((|pterm[NS-1:0]) | exp_in) ^ invert;
  end
endmodule : clc_sop

//--- rtl/clc_store.sv
// Programmable storage element: edge flipflop, flow-through latch or bypass.
`timescale 1ns/100ps
module clc_store
  import clc_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic d,
  input  wire logic ck,
  input  wire logic ena,
  input  wire logic latch,
  input  wire logic bypass,
  input  wire logic clr,
  input  wire logic pre,
  output logic      q,
  output logic      y
);
  typedef struct packed {
    logic ck_prev;
    logic q;
  } clc_store_st_t;

  clc_store_st_t st_reg;
  clc_store_st_t st_next;

  // The cell clock is a sampled level, so it must stay below half the bus clock rate.
  always_comb begin
    st_next = st_reg;
    st_next.ck_prev = ck;
    if (clr) begin
      st_next.q = 1'b0;
    end else if (pre) begin
      st_next.q = 1'b1;
    end else if (latch) begin
      if (ck && ena) begin
        st_next.q = d;
      end
    end else if (ck && !st_reg.ck_prev && ena) begin
      st_next.q = d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Unless bypass is set, clear and preset also force the output at once, without waiting for any edge.
  always_comb begin
    if (bypass) begin
      y = d;
    end else if (clr) begin
      y = 1'b0;
    end else if (pre) begin
      y = 1'b1;
    end else if (latch && ck && ena) begin
      y = d;
    end else begin
      y = st_reg.q;
    end
  end

  assign q = st_reg.q;
endmodule : clc_store

//--- rtl/clc_top.sv
// Configurable logic cell top: AXI4-Lite registers, both cell variants and pin control.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "clc_defines.svh"
module clc_top
  import clc_pkg::*;
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [`CLC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`CLC_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     gclk_pin,
  input  wire logic [3:0]               ded_in,
  input  wire logic [`CLC_N_IO-1:0]     io_in,
  output logic      [`CLC_N_IO-1:0]     io_out,
  output logic      [`CLC_N_IO-1:0]     io_oe_n,
  input  wire logic                     exp_in,
  output logic                          exp_out,
  input  wire logic                     carry_in,
  output logic                          carry_out,
  input  wire logic                     casc_in,
  output logic                          casc_out
);
  localparam int NI = 8;
  localparam int NT = 2 * `CLC_TERM_REGS - 1;

  typedef struct packed {
    logic [31:0]                     sop_ctrl;
    logic [31:0]                     lut_ctrl;
    logic [15:0]                     lut_tab;
    logic [31:0]                     io_ctrl;
    logic [`CLC_TERM_REGS-1:0][31:0] term;
    logic                            gclk_prev;
    logic [`CLC_N_IO-1:0]            pin_in_q;
    logic [`CLC_N_IO-1:0]            pin_out_q;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            rvalid;
    logic [1:0]                      rresp;
    logic [31:0]                     rdata;
  } clc_top_st_t;

  clc_top_st_t                 st_reg;
  clc_top_st_t                 st_next;
  clc_scfg_t                   sop_cfg;
  clc_scfg_t                   lut_cfg;
  clc_iocfg_t [`CLC_N_IO-1:0]  io_cfg;
  logic [NI-1:0]               arr_in;
  logic [NT-1:0][NI-1:0]       tmask;
  logic [NT-1:0][NI-1:0]       cmask;
  logic [NT-1:0]               pterm;
  logic                        sop_sum;
  logic                        sop_q;
  logic                        sop_y;
  logic                        sop_ck;
  logic                        sop_ena;
  logic                        lut_o;
  logic                        lut_q;
  logic                        lut_y;
  logic                        lut_ck;
  logic                        lut_ena;
  logic                        lut_clr;
  logic                        lut_pre;
  logic                        carry_mode;
  logic [3:0]                  ld;
  logic [`CLC_N_IO-1:0]        pin_fb;
  logic [`CLC_N_IO-1:0]        cell_pin;
  logic [`CLC_N_IO-1:0]        oe_sig;
  logic                        gclk_rise;
  logic                        wr_go;
  logic                        rd_go;
  logic [`CLC_ADDR_W-1:0]      woff;
  logic [`CLC_ADDR_W-1:0]      roff;
  logic [`CLC_ADDR_W-1:0]      wterm;
  logic [`CLC_ADDR_W-1:0]      rterm;
  logic [31:0]                 status;

  function automatic logic [31:0] clc_wr(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction : clc_wr

  assign sop_cfg    = clc_scfg_t'(st_reg.sop_ctrl[`CLC_SCFG_W-1:0]);
  assign lut_cfg    = clc_scfg_t'(st_reg.lut_ctrl[`CLC_SCFG_W-1:0]);
  assign carry_mode = st_reg.lut_ctrl[`CLC_LUT_CARRY_BIT];
  assign gclk_rise  = gclk_pin && !st_reg.gclk_prev;

  // Cell outputs return through their own path, so a pin stays free as an input.
  assign arr_in = {lut_q, sop_q, ded_in[1:0], pin_fb};

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      tmask[t] = st_reg.term[t/2][`CLC_TERM_W*(t%2) +: `CLC_MASK_W];
      cmask[t] = st_reg.term[t/2][`CLC_TERM_W*(t%2)+`CLC_MASK_W +: `CLC_MASK_W];
    end
  end

  clc_sop #(
    .NI (NI),
    .NT (NT),
    .NS (`CLC_PT_SUMS)
  ) u_sop (
    .arr_in (arr_in),
    .tmask  (tmask),
    .cmask  (cmask),
    .exp_in (exp_in && st_reg.sop_ctrl[`CLC_SOP_STEAL_BIT]),
    .invert (st_reg.sop_ctrl[`CLC_SOP_INV_BIT]),
    .pterm  (pterm),
    .sum_y  (sop_sum)
  );

  // The last sum term is always offered to the neighbouring cell.
  assign exp_out = pterm[`CLC_PT_SUMS-1];

  always_comb begin
    unique case (sop_cfg.clk_src)
      CLC_CK_GPIN: sop_ck = gclk_pin;
      CLC_CK_PIN:  sop_ck = io_in[sop_cfg.clk_pin];
      CLC_CK_INT:  sop_ck = pterm[`CLC_PT_CLK] ^ sop_cfg.falling;
      CLC_CK_RSVD: sop_ck = 1'b0;
    endcase
    sop_ena = !sop_cfg.ena_use || pterm[`CLC_PT_ENA];
    unique case (lut_cfg.clk_src)
      CLC_CK_GPIN: lut_ck = gclk_pin ^ lut_cfg.falling;
      CLC_CK_PIN:  lut_ck = io_in[lut_cfg.clk_pin] ^ lut_cfg.falling;
      CLC_CK_INT:  lut_ck = pterm[`CLC_PT_CLK] ^ lut_cfg.falling;
      CLC_CK_RSVD: lut_ck = 1'b0;
    endcase
    lut_clr = ded_in[2] ^ lut_cfg.clr_inv;
    lut_pre = ded_in[3] ^ lut_cfg.pre_inv;
    lut_ena = !lut_cfg.ena_use || (ded_in[1] ^ lut_cfg.ena_inv);
  end

  clc_store u_sop_ff (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (sop_sum),
    .ck      (sop_ck),
    .ena     (sop_ena),
    .latch   (sop_cfg.latch),
    .bypass  (sop_cfg.bypass),
    .clr     (pterm[`CLC_PT_CLR]),
    .pre     (pterm[`CLC_PT_PRE]),
    .q       (sop_q),
    .y       (sop_y)
  );

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      ld[k] = arr_in[st_reg.lut_ctrl[`CLC_LUT_SEL_LSB + `CLC_LUT_SEL_W*k +: `CLC_LUT_SEL_W]];
    end
    // In arithmetic mode the third table input carries the incoming carry.
    if (carry_mode) begin
      ld[2] = carry_in;
    end
    lut_o = st_reg.lut_tab[ld];
    carry_out = carry_mode && ((ld[0] && ld[1]) || (ld[0] && carry_in)
                || (ld[1] && carry_in));
    if (!st_reg.lut_ctrl[`CLC_LUT_CASC_BIT]) begin
      casc_out = lut_o;
    end else if (st_reg.lut_ctrl[`CLC_LUT_COR_BIT]) begin
      casc_out = lut_o || casc_in;
    end else begin
      casc_out = lut_o && casc_in;
    end
  end

  // The small cell has no latch mode; only the sum-of-products storage offers it.
  clc_store u_lut_ff (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (casc_out),
    .ck      (lut_ck),
    .ena     (lut_ena),
    .latch   (1'b0),
    .bypass  (lut_cfg.bypass),
    .clr     (lut_clr),
    .pre     (lut_pre),
    .q       (lut_q),
    .y       (lut_y)
  );

  always_comb begin
    for (int i = 0; i < `CLC_N_IO; i++) begin
      io_cfg[i]   = clc_iocfg_t'(st_reg.io_ctrl[`CLC_IOCFG_W*i +: `CLC_IOCFG_W]);
      cell_pin[i] = io_cfg[i].out_lut ? lut_y : sop_y;
      pin_fb[i]   = (io_cfg[i].reg_en && io_cfg[i].mode == CLC_IO_IN) ? st_reg.pin_in_q[i]
                    : io_in[i];
      io_out[i]   = io_cfg[i].reg_en ? st_reg.pin_out_q[i] : cell_pin[i];
      unique case (io_cfg[i].oe_src)
        CLC_OE_TERM:  oe_sig[i] = pterm[`CLC_PT_OE];
        CLC_OE_DED:   oe_sig[i] = ded_in[0];
        CLC_OE_PIN:   oe_sig[i] = io_in[io_cfg[i].oe_pin];
        CLC_OE_LOGIC: oe_sig[i] = lut_y;
      endcase
      unique case (io_cfg[i].mode)
        CLC_IO_OUT:   io_oe_n[i] = 1'b0;
        CLC_IO_BIDIR: io_oe_n[i] = !oe_sig[i];
        CLC_IO_IN:    io_oe_n[i] = 1'b1;
        CLC_IO_OFF:   io_oe_n[i] = 1'b1;
      endcase
    end
  end

  assign status = {22'h0, casc_out, carry_out, io_in, lut_y, sop_y, lut_q, sop_q};

  // Address and data are taken together, which keeps the slave free of a skid buffer.
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = !st_reg.rvalid;
  assign wr_go         = s_axi_awready;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign woff          = {s_axi_awaddr[`CLC_ADDR_W-1:2], 2'b00};
  assign roff          = {s_axi_araddr[`CLC_ADDR_W-1:2], 2'b00};
  assign wterm         = woff - `CLC_OFS_TERM0;
  assign rterm         = roff - `CLC_OFS_TERM0;

  always_comb begin
    st_next = st_reg;
    st_next.gclk_prev = gclk_pin;
    if (gclk_rise) begin
      st_next.pin_in_q  = io_in;
      st_next.pin_out_q = cell_pin;
    end
    if (wr_go) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = `CLC_RESP_OKAY;
      if (woff == `CLC_OFS_SOP_CTRL) begin
        st_next.sop_ctrl = clc_wr(st_reg.sop_ctrl, s_axi_wdata, s_axi_wstrb);
      end else if (woff == `CLC_OFS_LUT_CTRL) begin
        st_next.lut_ctrl = clc_wr(st_reg.lut_ctrl, s_axi_wdata, s_axi_wstrb);
      end else if (woff == `CLC_OFS_LUT_TABLE) begin
        st_next.lut_tab = 16'(clc_wr({16'h0, st_reg.lut_tab}, s_axi_wdata,
                                     s_axi_wstrb));
      end else if (woff == `CLC_OFS_IO_CTRL) begin
        st_next.io_ctrl = clc_wr(st_reg.io_ctrl, s_axi_wdata, s_axi_wstrb);
      end else if (wterm < `CLC_TERM_SPAN) begin
        st_next.term[wterm[4:2]] = clc_wr(st_reg.term[wterm[4:2]], s_axi_wdata,
                                          s_axi_wstrb);
      end else if (woff != `CLC_OFS_STATUS) begin
        st_next.bresp = `CLC_RESP_SLVERR;
      end
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `CLC_RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (roff == `CLC_OFS_SOP_CTRL) begin
        st_next.rdata = st_reg.sop_ctrl;
      end else if (roff == `CLC_OFS_LUT_CTRL) begin
        st_next.rdata = st_reg.lut_ctrl;
      end else if (roff == `CLC_OFS_LUT_TABLE) begin
        st_next.rdata = {16'h0, st_reg.lut_tab};
      end else if (roff == `CLC_OFS_IO_CTRL) begin
        st_next.rdata = st_reg.io_ctrl;
      end else if (rterm < `CLC_TERM_SPAN) begin
        st_next.rdata = st_reg.term[rterm[4:2]];
      end else if (roff == `CLC_OFS_STATUS) begin
        st_next.rdata = status;
      end else begin
        st_next.rresp = `CLC_RESP_SLVERR;
      end
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= '0;
      st_reg.sop_ctrl <= `CLC_RST_CTRL;
      st_reg.lut_ctrl <= `CLC_RST_CTRL;
      st_reg.lut_tab  <= `CLC_RST_TABLE;
      st_reg.io_ctrl  <= `CLC_RST_IO;
      st_reg.term     <= {`CLC_TERM_REGS{`CLC_RST_TERM}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp  = st_reg.rresp;
  assign s_axi_rdata  = st_reg.rdata;
endmodule : clc_top
